/* File: core/tbds_top.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module tbds_top #(
   parameter int HICCUP_CYC = tbds_pkg::HICCUP_SW
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Two-wire serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // External sync clock
   input wire logic sync_clk_in,
   // Channel pins and comparators
   input wire logic [2:0] channel_on_pin,
   input wire logic [2:0] pg_cmp,
   input wire logic [2:0] ov_cmp,
   input wire logic [2:0] oc_cmp,
   input wire logic [2:0] boot_low,
   input wire logic therm_hot,
   // Power stage control
   output logic [2:0] ch_run,
   output logic [2:0] hs_off,
   output logic [2:0] ls_force,
   output logic [2:0] light_load_skip_mode,
   output logic [2:0] sw_clk,
   output logic sync_locked,
   // Channel two voltage setting
   output logic use_code_divider,
   output logic [6:0] target_voltage_code,
   // Status
   output logic power_ok_output
);
   // ----------------------------------------
   // Reset and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_ff;
   logic rst_n;
   logic [18:0] in_m;
   logic [18:0] in_s;
   logic scl_q, sda_q, sync_q;
   logic scl_s, sda_s, sync_s, hot;
   logic [2:0] pin_s, pg_s, ov_s, oc_s, bl_s;

   // Release reset through two flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_ff <= 2'h0;
      end else begin
         rst_ff <= {rst_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_ff[1];

   // Two-flop synchronisers, third stage for edges
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_m <= 19'h0;
         in_s <= 19'h0;
         scl_q <= 1'b0;
         sda_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         in_m <= {therm_hot, boot_low, oc_cmp, ov_cmp, pg_cmp, channel_on_pin,
                  sync_clk_in, sda_in, scl_in};
         in_s <= in_m;
         scl_q <= scl_s;
         sda_q <= sda_s;
         sync_q <= sync_s;
      end
   end
   assign {hot, bl_s, oc_s, ov_s, pg_s, pin_s, sync_s, sda_s, scl_s} = in_s;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] ctrl;
   logic [6:0] vcode;
   logic bus_present;
   logic i2c_we;
   logic [1:0] i2c_idx;
   logic [7:0] i2c_dat;
   logic wr_en;
   logic [1:0] wr_idx;
   logic [7:0] wr_dat;
   wire [2:0] ch_is_run;
   wire [2:0] ch_in_hic;
   localparam logic [7:0] OFS_CTRL = tbds_pkg::OFS_CTRL;
   localparam logic [7:0] OFS_VCODE = tbds_pkg::OFS_VCODE;
   localparam logic [7:0] OFS_CMD = tbds_pkg::OFS_CMD;
   localparam int CMD_GO_BIT = tbds_pkg::CMD_GO_BIT;
   localparam int CMD_PG_LSB = tbds_pkg::CMD_PG_LSB;
   localparam int CMD_POK_BIT = tbds_pkg::CMD_POK_BIT;
   localparam int STAT_HIC_LSB = tbds_pkg::STAT_HIC_LSB;
   localparam int STAT_HOT_BIT = tbds_pkg::STAT_HOT_BIT;
   localparam int STAT_OV_LSB = tbds_pkg::STAT_OV_LSB;
   localparam int STAT_BUS_BIT = tbds_pkg::STAT_BUS_BIT;
   localparam int CTRL_ON_LSB = tbds_pkg::CTRL_ON_LSB;
   localparam int CTRL_SKIP_LSB = tbds_pkg::CTRL_SKIP_LSB;
   localparam logic [1:0] IDX_CTRL = OFS_CTRL[3:2];
   localparam logic [1:0] IDX_VCODE = OFS_VCODE[3:2];
   localparam logic [1:0] IDX_CMD = OFS_CMD[3:2];

   // Check that a port byte address is an aligned word in the map
   function automatic logic map_ok(input logic [7:0] a);
      map_ok = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
   endfunction

   // Read view shared by the port and the serial bus
   function automatic logic [7:0] tbds_rd(input logic [1:0] idx);
      tbds_rd = 8'h00;
      case (idx)
         OFS_CTRL[3:2]: tbds_rd = ctrl;
         OFS_VCODE[3:2]: tbds_rd = {1'b0, vcode};
         OFS_CMD[3:2]: begin
            tbds_rd[CMD_GO_BIT] = use_code_divider;
            tbds_rd[CMD_PG_LSB +: 3] = pg_s;
            tbds_rd[CMD_POK_BIT] = power_ok_output;
         end
         default: begin
            tbds_rd[STAT_HIC_LSB +: 3] = ch_in_hic;
            tbds_rd[STAT_HOT_BIT] = hot;
            tbds_rd[STAT_OV_LSB +: 3] = ov_s;
            tbds_rd[STAT_BUS_BIT] = bus_present;
         end
      endcase
   endfunction

   // Serial writes win over a same-cycle port write
   always_comb begin
      wr_en = i2c_we | (reg_wr & map_ok(reg_addr));
      wr_idx = i2c_we ? i2c_idx : reg_addr[3:2];
      wr_dat = i2c_we ? i2c_dat : reg_wdata;
   end

   // Control and code registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= tbds_pkg::CTRL_RST;
         vcode <= tbds_pkg::VCODE_RST;
      end else if (wr_en) begin
         if (wr_idx == IDX_CTRL) begin
            ctrl <= wr_dat;
         end
         if (wr_idx == IDX_VCODE) begin
            vcode <= wr_dat[6:0];
         end
      end
   end

   // Code takes effect only on the trigger bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         use_code_divider <= 1'b0;
         target_voltage_code <= tbds_pkg::VCODE_RST;
      end else if (!bus_present) begin
         use_code_divider <= 1'b0;
      end else if (wr_en && wr_idx == IDX_CMD && wr_dat[CMD_GO_BIT]) begin
         use_code_divider <= 1'b1;
         target_voltage_code <= vcode;
      end
   end

   // Port read data in the following cycle only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && map_ok(reg_addr)) begin
         reg_rdata <= tbds_rd(reg_addr[3:2]);
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Bus counts as present once either line is seen high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_present <= 1'b0;
      end else if (scl_s | sda_s) begin
         bus_present <= 1'b1;
      end
   end

   // ----------------------------------------
   // Serial bus target
   // ----------------------------------------
   tbds_pkg::tbds_ser_t st;
   logic [3:0] bitc;
   logic [7:0] shf;
   logic [7:0] rd_byte;
   logic [1:0] ptr;
   logic rw, first, mack;
   logic start, stop, rise, fall;

   // Line events, and the byte to send, kept fresh as registers change
   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop = scl_s & scl_q & ~sda_q & sda_s;
   assign rise = scl_s & ~scl_q;
   assign fall = ~scl_s & scl_q;
   always_comb rd_byte = tbds_rd(ptr);

   // Byte framing, acknowledge and register pointer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= tbds_pkg::I_IDLE;
         bitc <= 4'h0;
         shf <= 8'h00;
         ptr <= 2'h0;
         rw <= 1'b0;
         first <= 1'b0;
         mack <= 1'b0;
         sda_oe <= 1'b0;
         i2c_we <= 1'b0;
         i2c_idx <= 2'h0;
         i2c_dat <= 8'h00;
      end else begin
         i2c_we <= 1'b0;
         if (!bus_present || stop) begin
            st <= tbds_pkg::I_IDLE;
            sda_oe <= 1'b0;
         end else if (start) begin
            st <= tbds_pkg::I_ADDR;
            bitc <= 4'h0;
            sda_oe <= 1'b0;
         end else if (rise) begin
            case (st)
               tbds_pkg::I_ADDR, tbds_pkg::I_WR: begin
                  shf <= {shf[6:0], sda_s};
                  bitc <= bitc + 4'h1;
               end
               tbds_pkg::I_ACKR: mack <= ~sda_s;
               default: ;
            endcase
         end else if (fall) begin
            case (st)
               tbds_pkg::I_ADDR: if (bitc == 4'h8) begin
                  if (shf[7:1] == tbds_pkg::TGT_ADDR) begin
                     sda_oe <= 1'b1;
                     rw <= shf[0];
                     st <= tbds_pkg::I_ACKA;
                  end else begin
                     st <= tbds_pkg::I_IDLE;
                  end
               end
               tbds_pkg::I_WR: if (bitc == 4'h8) begin
                  sda_oe <= 1'b1;
                  st <= tbds_pkg::I_ACKW;
                  first <= 1'b0;
                  if (first) begin
                     ptr <= shf[1:0];
                  end else begin
                     i2c_we <= 1'b1;
                     i2c_idx <= ptr;
                     i2c_dat <= shf;
                     ptr <= ptr + 2'h1;
                  end
               end
               tbds_pkg::I_ACKA, tbds_pkg::I_ACKR: begin
                  if ((st == tbds_pkg::I_ACKA && rw) || (st == tbds_pkg::I_ACKR && mack)) begin
                     shf <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     ptr <= ptr + 2'h1;
                     bitc <= 4'h0;
                     st <= tbds_pkg::I_RD;
                  end else if (st == tbds_pkg::I_ACKA) begin
                     sda_oe <= 1'b0;
                     bitc <= 4'h0;
                     first <= 1'b1;
                     st <= tbds_pkg::I_WR;
                  end else begin
                     st <= tbds_pkg::I_IDLE;
                  end
               end
               tbds_pkg::I_ACKW: begin
                  sda_oe <= 1'b0;
                  bitc <= 4'h0;
                  st <= tbds_pkg::I_WR;
               end
               tbds_pkg::I_RD: if (bitc == 4'h7) begin
                  sda_oe <= 1'b0;
                  st <= tbds_pkg::I_ACKR;
               end else begin
                  sda_oe <= ~shf[6];
                  shf <= {shf[6:0], 1'b0};
                  bitc <= bitc + 4'h1;
               end
               default: ;
            endcase
         end
      end
   end

   // Open-drain data line only ever pulls low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Switching clock and external sync
   // ----------------------------------------
   logic [6:0] ph, per, ecnt;
   logic sync_fall, tick;
   assign sync_fall = sync_q & ~sync_s;
   assign tick = (ph == 7'h00);

   // Phase counter restarts on each valid sync falling edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 7'h00;
         per <= 7'(tbds_pkg::SW_PER_CYC);
         ecnt <= 7'h00;
         sync_locked <= 1'b0;
      end else begin
         ecnt <= sync_fall ? 7'h00 : ((ecnt == 7'h7F) ? ecnt : ecnt + 7'h01);
         if (sync_fall && ecnt >= 7'(tbds_pkg::SYNC_MIN_CYC - 1)
             && ecnt <= 7'(tbds_pkg::SYNC_MAX_CYC - 1)) begin
            sync_locked <= 1'b1;
            per <= ecnt + 7'h01;
            ph <= 7'h00;
         end else begin
            if (sync_fall || ecnt > 7'(tbds_pkg::SYNC_MAX_CYC)) begin
               sync_locked <= 1'b0;
               per <= 7'(tbds_pkg::SW_PER_CYC);
            end
            ph <= (ph >= per - 7'h01) ? 7'h00 : ph + 7'h01;
         end
      end
   end

   // Channel one runs half a period from the other two
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_clk <= 3'h0;
      end else begin
         sw_clk <= {{2{ph >= {1'b0, per[6:1]}}}, ph < {1'b0, per[6:1]}};
      end
   end

   // ----------------------------------------
   // Channel sequencing and protection
   // ----------------------------------------
   logic [2:0] want_on;
   // Host bits only count with a live bus
   assign want_on = pin_s & (bus_present ? ctrl[CTRL_ON_LSB +: 3] : 3'h7);

   for (genvar c = 0; c < 3; c++) begin : g_ch
      tbds_pkg::tbds_ch_t cs;
      logic [8:0] oc_cnt;
      logic [13:0] hic_cnt;
      assign ch_is_run[c] = (cs == tbds_pkg::CH_RUN);
      assign ch_in_hic[c] = (cs == tbds_pkg::CH_HIC);

      // Off, running, or waiting out a hiccup
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            cs <= tbds_pkg::CH_OFF;
            oc_cnt <= 9'h000;
            hic_cnt <= 14'h0000;
         end else begin
            case (cs)
               tbds_pkg::CH_OFF: begin
                  oc_cnt <= 9'h000;
                  hic_cnt <= 14'h0000;
                  if (want_on[c] && !hot) begin
                     cs <= tbds_pkg::CH_RUN;
                  end
               end
               tbds_pkg::CH_RUN: begin
                  if (!want_on[c] || hot) begin
                     cs <= tbds_pkg::CH_OFF;
                  end else if (tick) begin
                     if (!oc_s[c]) begin
                        oc_cnt <= 9'h000;
                     end else if (oc_cnt == 9'(tbds_pkg::OC_WAIT_SW)) begin
                        cs <= tbds_pkg::CH_HIC;
                     end else begin
                        oc_cnt <= oc_cnt + 9'h001;
                     end
                  end
               end
               tbds_pkg::CH_HIC: begin
                  if (hot) begin
                     cs <= tbds_pkg::CH_OFF;
                  end else if (tick) begin
                     if (hic_cnt == 14'(HICCUP_CYC - 1)) begin
                        cs <= tbds_pkg::CH_OFF;
                     end else begin
                        hic_cnt <= hic_cnt + 14'h0001;
                     end
                  end
               end
               default: cs <= tbds_pkg::CH_OFF;
            endcase
         end
      end
   end

   // Power stage drive per channel
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ch_run <= 3'h0;
         hs_off <= 3'h7;
         ls_force <= 3'h0;
         light_load_skip_mode <= 3'h7;
      end else begin
         ch_run <= ch_is_run;
         hs_off <= ~ch_is_run | ov_s | bl_s;
         ls_force <= ch_is_run & bl_s;
         light_load_skip_mode <= bus_present ? ~ctrl[CTRL_SKIP_LSB +: 3] : 3'h7;
      end
   end

   // ----------------------------------------
   // Power ok deglitch
   // ----------------------------------------
   logic pg_raw;
   logic [9:0] pg_cnt;
   assign pg_raw = (&pg_s) & (&ch_is_run) & ~hot;

   // Change reported after a steady run of switching cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_ok_output <= 1'b0;
         pg_cnt <= 10'h000;
      end else if (pg_raw == power_ok_output) begin
         pg_cnt <= 10'h000;
      end else if (tick) begin
         if ((power_ok_output && pg_cnt == 10'(tbds_pkg::PG_FALL_SW - 1))
             || (!power_ok_output && pg_cnt == 10'(tbds_pkg::PG_RISE_SW - 1))) begin
            power_ok_output <= pg_raw;
            pg_cnt <= 10'h000;
         end else begin
            pg_cnt <= pg_cnt + 10'h001;
         end
      end
   end
endmodule

/* File: core/tbds_pkg.sv */
// Summary of operation
// - Host switches channels, sets channel two, reads status
// - Channel two target is a 7-bit 10 mV code
// - New code applies only after trigger bit write
// - Channel two starts on external divider
// - Dead bus lines mean pin-only stand-alone operation
// - Pin-only mode: each enable pin controls channel
// - Light-load skipping unless host disables it
// - Lock switching cycle to external clock falling edge
// - Channel one clock 180 degrees from others
// - Power ok needs all channels regulated, sequence done
// - Host reads each power-good comparator state
// - Overvoltage holds high-side switch off until cleared
// - Overcurrent past 256 cycles: shut, hiccup 8192
// - Thermal recovery restarts channels through soft-start; the code has no soft-start and moves each channel straight from off to run
// - Low bootstrap forces switch node low
// - Unconnected enable pin counts as enabled
// - Falling power ok deglitched 112 switching cycles
// - Rising power ok deglitched 616 switching cycles
// - Trigger moves channel two to internal divider
package tbds_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_KHZ = 20000;
   localparam int SW_KHZ = 500;
   localparam int SYNC_MIN_KHZ = 200;
   localparam int SYNC_MAX_KHZ = 2300;
   localparam int SW_PER_CYC = CLK_KHZ / SW_KHZ;
   localparam int SYNC_MIN_CYC = (CLK_KHZ + SYNC_MAX_KHZ - 1) / SYNC_MAX_KHZ;
   localparam int SYNC_MAX_CYC = CLK_KHZ / SYNC_MIN_KHZ;
   localparam int OC_WAIT_SW = 256;
   localparam int HICCUP_SW = 8192;
   localparam int PG_FALL_SW = 112;
   localparam int PG_RISE_SW = 616;
   // ----------------------------------------
   // Bus target and register map
   // ----------------------------------------
   localparam logic [6:0] TGT_ADDR = 7'h60;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VCODE = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam int CTRL_ON_LSB = 0;
   localparam int CTRL_SKIP_LSB = 4;
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_PG_LSB = 4;
   localparam int CMD_POK_BIT = 7;
   localparam int STAT_HIC_LSB = 0;
   localparam int STAT_HOT_BIT = 3;
   localparam int STAT_OV_LSB = 4;
   localparam int STAT_BUS_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h07;
   localparam logic [6:0] VCODE_RST = 7'h00;
   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [6:0] {
      I_IDLE = 7'h01, I_ADDR = 7'h02, I_ACKA = 7'h04, I_WR = 7'h08,
      I_ACKW = 7'h10, I_RD = 7'h20, I_ACKR = 7'h40
   } tbds_ser_t;
   typedef enum logic [2:0] {
      CH_OFF = 3'h1, CH_RUN = 3'h2, CH_HIC = 3'h4
   } tbds_ch_t;
endpackage

/* File: bench/tbds_sva.sv */
`timescale 1ns/1ps
module tbds_sva #(
   parameter int HICCUP_CYC = tbds_pkg::HICCUP_SW
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Comparators
   input wire logic [2:0] pg_cmp,
   input wire logic [2:0] oc_cmp,
   input wire logic [2:0] boot_low,
   input wire logic therm_hot,
   // Watched outputs
   input wire logic [2:0] ch_run,
   input wire logic [2:0] hs_off,
   input wire logic [2:0] ls_force,
   input wire logic [2:0] sw_clk,
   input wire logic use_code_divider,
   input wire logic [6:0] target_voltage_code,
   input wire logic power_ok_output
);
   localparam int SW = tbds_pkg::SW_PER_CYC;
   logic good;
   int good_cnt, bad_cnt, oc_cnt, off_cnt;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // ---------------------------------
   // Run lengths
   // ---------------------------------
   assign good = ch_run == 3'h7 && pg_cmp == 3'h7 && !therm_hot;
   // Counts stretches of good, bad, overcurrent and channel one off
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         good_cnt <= 0;
         bad_cnt <= 0;
         oc_cnt <= 0;
         off_cnt <= 0;
      end else begin
         good_cnt <= good ? good_cnt + 1 : 0;
         bad_cnt <= good ? 0 : bad_cnt + 1;
         oc_cnt <= (oc_cmp[0] && ch_run[0]) ? oc_cnt + 1 : 0;
         off_cnt <= ch_run[0] ? 0 : off_cnt + 1;
      end
   end
   // ---------------------------------
   // Properties
   // ---------------------------------
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read");
   a_boot_force: assert property ((ch_run[1] && boot_low[1]) [*4]
      |-> ls_force[1] && hs_off[1])
      else $error("switch node not forced low");
   a_sw_phase: assert property (ch_run == 3'h7 && $rose(sw_clk[0])
      |-> $fell(sw_clk[1]) && $fell(sw_clk[2]))
      else $error("channel clocks not opposed");
   a_pok_rise: assert property ($rose(power_ok_output) |-> good_cnt >= 615 * SW)
      else $error("power ok rose early");
   a_pok_fall: assert property ($fell(power_ok_output) |-> bad_cnt >= 111 * SW)
      else $error("power ok fell early");
   a_pok_drop: assert property (power_ok_output |-> bad_cnt < 113 * SW + 8)
      else $error("power ok held too long");
   a_oc_limit: assert property (ch_run[0] |-> oc_cnt < 258 * SW + 8)
      else $error("overcurrent not shut down");
   a_hiccup_gap: assert property ($rose(ch_run[0]) && oc_cmp[0]
      |-> off_cnt >= (HICCUP_CYC - 1) * SW)
      else $error("hiccup too short");
   a_code_go: assert property ($changed(target_voltage_code) |-> use_code_divider)
      else $error("code changed without trigger");
   // Main scenarios
   c_pok: cover property ($rose(power_ok_output));
   c_hiccup: cover property ($fell(ch_run[0]) && oc_cmp[0]);
   c_go: cover property ($rose(use_code_divider));
endmodule
bind tbds_top tbds_sva #(.HICCUP_CYC(HICCUP_CYC)) i_tbds_sva (.sys_clk, .rst_b, .reg_rd,
   .reg_rdata, .pg_cmp, .oc_cmp, .boot_low, .therm_hot, .ch_run, .hs_off, .ls_force,
   .sw_clk, .use_code_divider, .target_voltage_code, .power_ok_output);

/* File: bench/tbds_host.sv */
`timescale 1ns/1ps
module tbds_host (
   // Clock and line state
   input wire logic sys_clk,
   input wire logic bus_gnd,
   input wire logic sda_oe,
   // Resolved bus lines
   output logic scl,
   output logic sda
);
   logic scl_r = 1'b1;
   logic low = 1'b0;
   // Pulled-up wired lines, both grounded while unused
   assign scl = bus_gnd ? 1'b0 : scl_r;
   assign sda = bus_gnd ? 1'b0 : ~(low | sda_oe);
   // Quarter bit: a 52-cycle period keeps the clock under 400 kHz
   task automatic q();
      repeat (13) @(posedge sys_clk);
   endtask
   // Start, also used as repeated start
   task automatic start();
      low <= 1'b0;
      q();
      scl_r <= 1'b1;
      q();
      low <= 1'b1;
      q();
      scl_r <= 1'b0;
      q();
   endtask
   task automatic stop();
      low <= 1'b1;
      q();
      scl_r <= 1'b1;
      q();
      low <= 1'b0;
      q();
   endtask
   // One bit: data set while the clock is low, sampled mid high
   task automatic bt(input logic b, output logic r);
      low <= ~b;
      q();
      scl_r <= 1'b1;
      q();
      r = sda;
      q();
      scl_r <= 1'b0;
      q();
   endtask
   // Byte MSB first, then the acknowledge bit
   task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
      bt(m, a);
   endtask
   task automatic probe(input logic [6:0] ad, output logic a);
      logic [7:0] r;
      start();
      xb({ad, 1'b0}, 1'b1, r, a);
      stop();
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic a);
      logic [7:0] r;
      logic a1, a2;
      start();
      xb({tbds_pkg::TGT_ADDR, 1'b0}, 1'b1, r, a1);
      xb(p, 1'b1, r, a2);
      xb(d, 1'b1, r, a);
      stop();
      a = a | a1 | a2;
   endtask
   // Pointer write, repeated start, one byte read closed by no-acknowledge
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic a);
      logic [7:0] r;
      logic a1, a2, a3;
      start();
      xb({tbds_pkg::TGT_ADDR, 1'b0}, 1'b1, r, a1);
      xb(p, 1'b1, r, a2);
      start();
      xb({tbds_pkg::TGT_ADDR, 1'b1}, 1'b1, r, a3);
      xb(8'hFF, 1'b1, d, a);
      stop();
      a = a1 | a2 | a3;
   endtask
endmodule

/* File: bench/tbds_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; \
   if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tbds_top_bench;
   localparam int HIC = 8;
   localparam int SW = tbds_pkg::SW_PER_CYC;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sync_clk_in = 1'b1;
   logic bus_gnd = 1'b1;
   logic therm_hot = 1'b0;
   logic [2:0] channel_on_pin = 3'h7;
   logic [2:0] pg_cmp = 3'h0;
   logic [2:0] ov_cmp = 3'h0;
   logic [2:0] oc_cmp = 3'h0;
   logic [2:0] boot_low = 3'h0;
   logic [7:0] reg_rdata, d;
   logic scl, sda, sda_out, sda_oe, sync_locked, use_code_divider, power_ok_output, ack;
   logic [2:0] ch_run, hs_off, ls_force, light_load_skip_mode, sw_clk;
   logic [6:0] target_voltage_code;
   int n_mismatch = 0;
   int checked = 0;
   int n;
   // System clock and a 400 ns external sync clock
   always #25 sys_clk = ~sys_clk;
   always #200 sync_clk_in = ~sync_clk_in;
   tbds_top #(.HICCUP_CYC(HIC)) i_tbds_top (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .sync_clk_in,
      .channel_on_pin, .pg_cmp, .ov_cmp, .oc_cmp, .boot_low, .therm_hot, .ch_run, .hs_off,
      .ls_force, .light_load_skip_mode, .sw_clk, .sync_locked, .use_code_divider,
      .target_voltage_code, .power_ok_output);
   tbds_host i_tbds_host (.sys_clk, .bus_gnd, .sda_oe, .scl, .sda);
   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic do_reset();
      rst_b <= 1'b0;
      cyc(8);
      rst_b <= 1'b1;
      cyc(3);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
      `CHK(reg_rdata, e)
   endtask
   // Counts cycles until power ok (sel 0) or channel one run (sel 1) reaches lvl
   task automatic wait_lvl(input logic sel, input logic lvl);
      n = 0;
      while ((sel ? ch_run[0] : power_ok_output) !== lvl && n < 40000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      cyc(90000);
      n_mismatch++;
      end_sim();
   end
   // ---------------------------------
   // Tests
   // ---------------------------------
   initial begin
      do_reset();
      cyc(4);
      `CHK(ch_run, 3'h7)
      `CHK(use_code_divider, 1'b0)
      rd(tbds_pkg::OFS_CTRL, 8'h07);
      channel_on_pin <= 3'h5;
      wr(tbds_pkg::OFS_CTRL, 8'h70);
      cyc(4);
      `CHK(ch_run, 3'h5)
      `CHK(light_load_skip_mode, 3'h7)
      rd(tbds_pkg::OFS_STAT, 8'h00);
      channel_on_pin <= 3'h7;
      bus_gnd <= 1'b0;
      cyc(10);
      rd(tbds_pkg::OFS_STAT, 8'h80);
      i_tbds_host.wr(8'h00, 8'h15, ack);
      `CHK(ack, 1'b0)
      cyc(4);
      `CHK(ch_run, 3'h5)
      `CHK(light_load_skip_mode, 3'h6)
      i_tbds_host.rd(8'h00, d, ack);
      `CHK(d, 8'h15)
      wr(tbds_pkg::OFS_CTRL, 8'h07);
      cyc(4);
      `CHK(ch_run, 3'h7)
      `CHK(light_load_skip_mode, 3'h7)
      wr(tbds_pkg::OFS_VCODE, 8'h7F);
      `CHK(target_voltage_code, 7'h00)
      rd(tbds_pkg::OFS_VCODE, 8'h7F);
      wr(tbds_pkg::OFS_CMD, 8'h01);
      `CHK(use_code_divider, 1'b1)
      `CHK(target_voltage_code, 7'h7F)
      i_tbds_host.wr(8'h01, 8'h00, ack);
      cyc(3);
      `CHK(target_voltage_code, 7'h7F)
      i_tbds_host.wr(8'h02, 8'h01, ack);
      cyc(3);
      `CHK(target_voltage_code, 7'h00)
      rd(8'h10, 8'h00);
      i_tbds_host.probe(7'h61, ack);
      `CHK(ack, 1'b1)
      pg_cmp <= 3'h7;
      wait_lvl(1'b0, 1'b1);
      `CHK(n >= 615 * SW && n <= 617 * SW + 8, 1'b1)
      rd(tbds_pkg::OFS_CMD, 8'hF1);
      pg_cmp <= 3'h5;
      wait_lvl(1'b0, 1'b0);
      `CHK(n >= 111 * SW && n <= 113 * SW + 8, 1'b1)
      rd(tbds_pkg::OFS_CMD, 8'h51);
      ov_cmp <= 3'h4;
      cyc(5);
      `CHK(hs_off, 3'h4)
      rd(tbds_pkg::OFS_STAT, 8'hC0);
      ov_cmp <= 3'h0;
      boot_low <= 3'h2;
      cyc(5);
      `CHK(ls_force, 3'h2)
      boot_low <= 3'h0;
      therm_hot <= 1'b1;
      cyc(5);
      `CHK(ch_run, 3'h0)
      rd(tbds_pkg::OFS_STAT, 8'h88);
      therm_hot <= 1'b0;
      cyc(6);
      `CHK(ch_run, 3'h7)
      oc_cmp <= 3'h1;
      wait_lvl(1'b1, 1'b0);
      `CHK(n >= 256 * SW && n <= 258 * SW + 8, 1'b1)
      rd(tbds_pkg::OFS_STAT, 8'h81);
      wait_lvl(1'b1, 1'b1);
      `CHK(n >= (HIC - 1) * SW && n <= (HIC + 1) * SW + 8, 1'b1)
      oc_cmp <= 3'h0;
      `CHK(sync_locked, 1'b0)
      do_reset();
      `CHK(target_voltage_code, 7'h00)
      `CHK(use_code_divider, 1'b0)
      end_sim();
   end
endmodule
